// ---- hw/cio_alu.sv ----
// combinational datapath for increment, or and left shift
module cio_alu
    import cio_pkg::*;
(
    cio_alu_if.alu bus // operands in, result and flags out
);

    // result and flag write enables per operation
    always_comb begin
        bus.result   = bus.fileIn;
        bus.carry    = 1'b0;
        bus.updZero  = 1'b0;
        bus.updCarry = 1'b0;
        case (bus.op)
            OP_INC_SKIP: begin
                bus.result = bus.fileIn + 8'h01;
            end
            OP_INC: begin
                bus.result  = bus.fileIn + 8'h01;
                bus.updZero = 1'b1;
            end
            OP_OR_LIT: begin
                bus.result  = bus.accIn | bus.literal;
                bus.updZero = 1'b1;
            end
            OP_OR_FILE: begin
                bus.result  = bus.accIn | bus.fileIn;
                bus.updZero = 1'b1;
            end
            OP_SHL: begin
                bus.result   = {bus.fileIn[6:0], 1'b0};
                bus.carry    = bus.fileIn[7];
                bus.updZero  = 1'b1;
                bus.updCarry = 1'b1;
            end
            default: begin
                bus.result = bus.fileIn; // jump and unknown ops touch nothing
            end
        endcase
    end

    // zero detect on the full 8-bit result
    assign bus.zero = (bus.result == 8'h00);

endmodule

// ---- hw/cio_alu_if.sv ----
// operand and result bundle between the execution core and its datapath
interface cio_alu_if;
    import cio_pkg::*;

    cio_op_e           op;       // decoded operation
    logic [DATA_W-1:0] accIn;    // accumulator operand
    logic [DATA_W-1:0] fileIn;   // file register operand
    logic [DATA_W-1:0] literal;  // immediate operand
    logic [DATA_W-1:0] result;   // 8-bit result
    logic              zero;     // result is zero
    logic              carry;    // carry out
    logic              updZero;  // op writes zero flag
    logic              updCarry; // op writes carry flag

    modport core (output op, accIn, fileIn, literal, input result, zero, carry, updZero, updCarry);
    modport alu  (input op, accIn, fileIn, literal, output result, zero, carry, updZero, updCarry);
endinterface

// ---- hw/cio_exec.sv ----
// execution core: increment, skip, or, left shift and absolute jump with flags and program counter
module cio_exec
    import cio_pkg::*;
(
    input  wire logic               sys_clk,        // core instruction clock
    input  wire logic               rst_b,          // async reset, active low
    input  wire logic               instrValid,     // instruction word present this cycle
    input  wire logic [INSTR_W-1:0] instrWord,      // instruction word
    input  wire logic [DATA_W-1:0]  fileRdData,     // contents of fileAddr, same cycle
    input  wire logic [LATCH_W-1:0] progLatchUpper, // upper program counter latch
    output logic      [ADDR_W-1:0]  fileAddr,       // file register read address
    output logic                    fileWrEn_q,     // one-cycle file write strobe
    output logic      [ADDR_W-1:0]  fileWrAddr_q,   // file write address
    output logic      [DATA_W-1:0]  fileWrData_q,   // file write data
    output logic      [DATA_W-1:0]  acc_q,          // accumulator
    output logic                    zeroFlag_q,     // zero flag
    output logic                    carryFlag_q,    // carry flag
    output logic      [PC_W-1:0]    pc_q,           // program counter
    output logic                    flushActive     // current slot is a forced no-op
);

    cio_alu_if  aluBus ();
    cio_state_e state_q;
    cio_state_e state_d;
    cio_op_e    opCur;
    logic       execute;
    logic       destFile;
    logic       skipTaken;
    logic       writesDest;
    logic [PC_W-1:0] jumpTarget;
    logic       jumpFlush_q; // pending flush came from a jump

    // decode only in a normal slot; a flush slot never reaches the datapath
    assign execute    = instrValid && (state_q == ST_EXEC);
    assign opCur      = execute ? cio_decode(instrWord) : OP_NONE;
    assign destFile   = instrWord[DEST_BIT];
    assign fileAddr   = instrWord[ADDR_W-1:0];
    assign skipTaken  = (opCur == OP_INC_SKIP) && aluBus.zero;
    assign jumpTarget = {progLatchUpper[LATCH_J_MSB:LATCH_J_LSB], instrWord[JUMP_K_MSB:0]};
    assign flushActive = (state_q == ST_FLUSH);

    // ops that deliver a result to acc or file (or-literal always to acc)
    assign writesDest = (opCur == OP_INC_SKIP) || (opCur == OP_INC) || (opCur == OP_OR_FILE)
                     || (opCur == OP_SHL);

    assign aluBus.op      = opCur;
    assign aluBus.accIn   = acc_q;
    assign aluBus.fileIn  = fileRdData;
    assign aluBus.literal = instrWord[DATA_W-1:0];

    cio_alu u_alu (
        .bus (aluBus)
    );

    // jump and taken skip spend one extra slot as a no-op
    always_comb begin
        state_d = ST_EXEC;
        case (state_q)
            ST_EXEC: begin
                if ((opCur == OP_JUMP) || skipTaken) begin
                    state_d = ST_FLUSH;
                end
            end
            ST_FLUSH: state_d = ST_EXEC;
            default:  state_d = ST_EXEC;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // accumulator: or-literal always, others when destination bit is 0
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= ACC_RESET;
        end else if (opCur == OP_OR_LIT) begin
            acc_q <= aluBus.result;
        end else if (writesDest && !destFile) begin
            acc_q <= aluBus.result;
        end
    end

    // file write-back when destination bit is 1; strobe lasts one cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fileWrEn_q   <= 1'b0;
            fileWrAddr_q <= '0;
            fileWrData_q <= '0;
        end else begin
            fileWrEn_q <= writesDest && destFile;
            if (writesDest && destFile) begin
                fileWrAddr_q <= fileAddr;
                fileWrData_q <= aluBus.result;
            end
        end
    end

    // flags change only where the op says so; jump and skip leave them
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            zeroFlag_q  <= 1'b0;
            carryFlag_q <= 1'b0;
        end else begin
            if (aluBus.updZero) begin
                zeroFlag_q <= aluBus.zero;
            end
            if (aluBus.updCarry) begin
                carryFlag_q <= aluBus.carry;
            end
        end
    end

    // program counter: flush after a skip steps over the dropped word,
    // flush after a jump holds the target already loaded
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= PC_RESET;
        end else if (opCur == OP_JUMP) begin
            pc_q <= jumpTarget;
        end else if (execute) begin
            pc_q <= pc_q + 15'h0001;
        end else if (flushActive && !jumpFlush_q) begin
            pc_q <= pc_q + 15'h0001;
        end
    end

    // remembers whether the pending flush belongs to a jump
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            jumpFlush_q <= 1'b0;
        end else begin
            jumpFlush_q <= (opCur == OP_JUMP);
        end
    end

    // helper captures for the checks below
    logic [DATA_W-1:0] resNow;
    logic [DATA_W-1:0] fileNow;
    logic [DATA_W-1:0] accNow;
    assign resNow  = aluBus.result;
    assign fileNow = fileRdData;
    assign accNow  = acc_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_skipTaken;
        (opCur == OP_INC_SKIP) && (fileNow == 8'hff);
    endsequence

    sequence s_twoSlot;
        flushActive ##1 !flushActive;
    endsequence

    sequence s_jump;
        opCur == OP_JUMP;
    endsequence

    chk_skip_noop: assert property (s_skipTaken |=> s_twoSlot)
        else $error("taken skip did not produce exactly one no-op slot");

    chk_skip_none: assert property ((opCur == OP_INC_SKIP) && (fileNow != 8'hff) |=> !flushActive)
        else $error("untaken skip inserted a no-op slot");

    chk_inc_skip_flags: assert property ((opCur == OP_INC_SKIP) |=> $stable(zeroFlag_q) && $stable(carryFlag_q))
        else $error("increment-with-skip changed a flag");

    chk_inc_zero_only: assert property ((opCur == OP_INC) |=>
        (zeroFlag_q == ($past(fileNow) == 8'hff)) && $stable(carryFlag_q))
        else $error("increment flag update wrong");

    chk_dest_acc: assert property (writesDest && !destFile |=> (acc_q == $past(resNow)) && !fileWrEn_q)
        else $error("acc destination not honoured");

    chk_dest_file: assert property (writesDest && destFile |=>
        fileWrEn_q && (fileWrData_q == $past(resNow)) && $stable(acc_q))
        else $error("file destination not honoured");

    chk_jump_target: assert property (s_jump |=> (pc_q == $past(jumpTarget)) ##1 (pc_q == $past(pc_q)))
        else $error("jump target or hold wrong");

    chk_jump_cycles: assert property (s_jump |=>
        ($stable(zeroFlag_q) && $stable(carryFlag_q)) ##0 s_twoSlot)
        else $error("jump not two cycles or touched flags");

    chk_or_literal: assert property ((opCur == OP_OR_LIT) |=>
        (acc_q == ($past(accNow) | $past(instrWord[DATA_W-1:0]))) && (zeroFlag_q == (acc_q == 8'h00)))
        else $error("or-literal result wrong");

    chk_or_file: assert property ((opCur == OP_OR_FILE) |=> zeroFlag_q == ($past(resNow) == 8'h00))
        else $error("or-file zero flag wrong");

    chk_shift_left: assert property ((opCur == OP_SHL) |=>
        (carryFlag_q == $past(fileNow[7])) && (zeroFlag_q == ($past(fileNow[6:0]) == 7'h00)))
        else $error("left shift carry or zero wrong");

    chk_single_cycle: assert property (execute && (opCur != OP_JUMP) && (opCur != OP_INC_SKIP) |=> !flushActive)
        else $error("single-cycle op stalled");

    // skip plus its no-op slot must step pc twice, past the dropped word
    chk_skip_pc: assert property (s_skipTaken |=> ##1 (pc_q == $past(pc_q, 2) + 15'h0002))
        else $error("taken skip did not step pc over the dropped word");

    chk_flush_noop: assert property (flushActive |=> $stable(acc_q) && !fileWrEn_q
        && $stable(zeroFlag_q) && $stable(carryFlag_q))
        else $error("no-op slot changed state");

    chk_unknown_op: assert property (execute && (opCur == OP_NONE) |=> $stable(acc_q) && !fileWrEn_q
        && (pc_q == $past(pc_q) + 15'h0001))
        else $error("unknown word changed more than pc");

    chk_shift_value: assert property ((opCur == OP_SHL) && !destFile |=>
        acc_q == {$past(fileNow[6:0]), 1'b0})
        else $error("left shift result wrong");

    chk_inc_value: assert property ((opCur == OP_INC) || (opCur == OP_INC_SKIP) |=>
        $past(resNow) == $past(fileNow) + 8'h01)
        else $error("increment result wrong");

endmodule

// ---- hw/cio_pkg.sv ----
// constants, types and decode helpers for the increment/or/shift/jump execution block
package cio_pkg;

    localparam int INSTR_W = 14;
    localparam int ADDR_W  = 7;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 15;
    localparam int LATCH_W = 7;

    // field positions inside the instruction word and the upper pc latch
    localparam int DEST_BIT    = 7;
    localparam int JUMP_K_MSB  = 10;
    localparam int LATCH_J_MSB = 6;
    localparam int LATCH_J_LSB = 3;

    // opcode patterns: six upper bits, jump uses the upper three
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
    localparam logic [5:0] OPC_INC      = 6'h0a;
    localparam logic [5:0] OPC_OR_FILE  = 6'h04;
    localparam logic [5:0] OPC_OR_LIT   = 6'h38;
    localparam logic [5:0] OPC_SHL      = 6'h35;
    localparam logic [2:0] OPC_JUMP     = 3'h5;

    // reset values
    localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

    // cycles taken by jump and by a taken skip
    localparam int LONG_OP_CYCLES = 2;

    typedef enum logic [6:0] {
        OP_NONE     = 7'h01,
        OP_INC_SKIP = 7'h02,
        OP_INC      = 7'h04,
        OP_JUMP     = 7'h08,
        OP_OR_LIT   = 7'h10,
        OP_OR_FILE  = 7'h20,
        OP_SHL      = 7'h40
    } cio_op_e;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'h1,
        ST_FLUSH = 2'h2
    } cio_state_e;

    // instruction word to operation; unknown words fall to OP_NONE
    function automatic cio_op_e cio_decode(input logic [INSTR_W-1:0] w);
        cio_op_e op;
        op = OP_NONE;
        if (w[13:11] == OPC_JUMP) begin
            op = OP_JUMP;
        end else begin
            case (w[13:8])
                OPC_INC_SKIP: op = OP_INC_SKIP;
                OPC_INC:      op = OP_INC;
                OPC_OR_FILE:  op = OP_OR_FILE;
                OPC_OR_LIT:   op = OP_OR_LIT;
                OPC_SHL:      op = OP_SHL;
                default:      op = OP_NONE;
            endcase
        end
        return op;
    endfunction

endpackage

// ---- verification/cpu_increment_or_shift_jump_ops_tb.sv ----
// self-checking bench for the increment/or/shift/jump execution core
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module cpu_increment_or_shift_jump_ops_tb
    import cio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               sys_clk;        // core clock
    logic               rst_b;          // async reset, active low
    logic               instrValid;     // word present
    logic [INSTR_W-1:0] instrWord;      // instruction word
    logic [DATA_W-1:0]  fileRdData;     // file read data
    logic [LATCH_W-1:0] progLatchUpper; // upper pc latch
    logic [ADDR_W-1:0]  fileAddr;       // file read address
    logic               fileWrEn_q;     // write strobe
    logic [ADDR_W-1:0]  fileWrAddr_q;   // write address
    logic [DATA_W-1:0]  fileWrData_q;   // write data
    logic [DATA_W-1:0]  acc_q;          // accumulator
    logic               zeroFlag_q;     // zero flag
    logic               carryFlag_q;    // carry flag
    logic [PC_W-1:0]    pc_q;           // program counter
    logic               flushActive;    // no-op slot
    logic [DATA_W-1:0]  eAcc;           // expected accumulator
    logic               eZ;             // expected zero
    logic               eC;             // expected carry
    logic [PC_W-1:0]    ePc;            // expected pc
    int                 fails;
    int                 n_checks;

    cio_exec DUT (.sys_clk(sys_clk), .rst_b(rst_b), .instrValid(instrValid), .instrWord(instrWord),
        .fileRdData(fileRdData), .progLatchUpper(progLatchUpper), .fileAddr(fileAddr),
        .fileWrEn_q(fileWrEn_q), .fileWrAddr_q(fileWrAddr_q), .fileWrData_q(fileWrData_q),
        .acc_q(acc_q), .zeroFlag_q(zeroFlag_q), .carryFlag_q(carryFlag_q), .pc_q(pc_q),
        .flushActive(flushActive));

    // free-running core clock, 10 ns period
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [INSTR_W-1:0] fw(input logic [5:0] o, input logic d, input logic [ADDR_W-1:0] a);
        return {o, d, a};
    endfunction

    // present one word for one edge; the file is read combinationally, so data goes with it
    task automatic issue(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] f);
        instrValid = 1'b1;
        instrWord  = w;
        fileRdData = f;
        #1;
        `CHK("fileAddr", w[6:0], fileAddr)
        @(posedge sys_clk);
        #1;
    endtask

    // drop valid so the next scenario starts from a quiet port
    task automatic idle();
        instrValid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // compare all architectural state; write outputs only matter while the strobe is up
    task automatic chk(input logic fl, input logic we, input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] wd);
        `CHK("acc", eAcc, acc_q)
        `CHK("zero", eZ, zeroFlag_q)
        `CHK("carry", eC, carryFlag_q)
        `CHK("pc", ePc, pc_q)
        `CHK("flush", fl, flushActive)
        `CHK("wrEn", we, fileWrEn_q)
        if (we) begin
            `CHK("wrAddr", wa, fileWrAddr_q)
            `CHK("wrData", wd, fileWrData_q)
        end
    endtask

    task automatic t_reset();
        eAcc = ACC_RESET;
        eZ   = 1'b0;
        eC   = 1'b0;
        ePc  = PC_RESET;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    // carry takes bit 7, zero enters bit 0, both flags follow the result
    task automatic t_shift();
        issue(fw(OPC_SHL, 1'b0, 7'h05), 8'h40);
        eAcc = 8'h80;
        eC   = 1'b0;
        eZ   = 1'b0;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
        issue(fw(OPC_SHL, 1'b1, 7'h06), 8'h80);
        eC  = 1'b1;
        eZ  = 1'b1;
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b1, 7'h06, 8'h00);
        issue(fw(OPC_SHL, 1'b0, 7'h07), 8'hc1);
        eAcc = 8'h82;
        eZ   = 1'b0;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    // carry is set beforehand so a stray carry update would show
    task automatic t_inc();
        issue(fw(OPC_INC, 1'b0, 7'h12), 8'hff);
        eAcc = 8'h00;
        eZ   = 1'b1;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
        issue(fw(OPC_INC, 1'b1, 7'h7f), 8'h41);
        eZ  = 1'b0;
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b1, 7'h7f, 8'h42);
    endtask

    // nonzero skip runs the next word; zero result with z clear proves flags are left alone
    task automatic t_skip();
        issue(fw(OPC_INC_SKIP, 1'b1, 7'h20), 8'h10);
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b1, 7'h20, 8'h11);
        issue(fw(OPC_INC_SKIP, 1'b0, 7'h21), 8'hff);
        eAcc = 8'h00;
        ePc  = ePc + 15'h0001;
        chk(1'b1, 1'b0, 7'h00, 8'h00);
        issue({OPC_OR_LIT, 8'hff}, 8'h00);
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    task automatic t_or();
        issue(fw(OPC_OR_FILE, 1'b1, 7'h30), 8'h00);
        eZ  = 1'b1;
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b1, 7'h30, 8'h00);
        issue({OPC_OR_LIT, 8'ha5}, 8'h00);
        eAcc = 8'ha5;
        eZ   = 1'b0;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
        issue(fw(OPC_OR_FILE, 1'b0, 7'h31), 8'h5a);
        eAcc = 8'hff;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    // unknown word only steps pc; an empty slot changes nothing at all
    task automatic t_unknown();
        issue(14'h0000, 8'h3c);
        ePc = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
        idle();
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    // reset inside a jump's no-op slot must drop the pending flush
    task automatic t_midreset();
        progLatchUpper = 7'h18;
        issue({OPC_JUMP, 11'h123}, 8'h00);
        ePc = {4'h3, 11'h123};
        chk(1'b1, 1'b0, 7'h00, 8'h00);
        rst_b = 1'b0;
        #1;
        t_reset();
        @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        issue({OPC_OR_LIT, 8'h0f}, 8'h00);
        eAcc = 8'h0f;
        ePc  = ePc + 15'h0001;
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    // latch values chosen so bits 6:3 and bits 3:0 give different upper pc bits
    task automatic t_jump(input logic [LATCH_W-1:0] lat, input logic [10:0] k);
        progLatchUpper = lat;
        issue({OPC_JUMP, k}, 8'h00);
        ePc = {lat[6:3], k};
        chk(1'b1, 1'b0, 7'h00, 8'h00);
        issue(fw(OPC_INC, 1'b0, 7'h01), 8'h07);
        chk(1'b0, 1'b0, 7'h00, 8'h00);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence: reset for 12 cycles, then scenarios back to back
    initial begin
        fails = 0;
        n_checks = 0;
        rst_b = 1'b0;
        instrValid = 1'b0;
        instrWord = '0;
        fileRdData = 8'h00;
        progLatchUpper = 7'h00;
        repeat (12) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_shift();
        t_inc();
        t_skip();
        t_or();
        t_jump(7'h5a, 11'h5a5);
        t_jump(7'h07, 11'h7ff);
        t_unknown();
        t_midreset();
        idle();
        test_done();
    end

    // watchdog: the run needs well under 100 cycles
    initial begin
        #20000;
        fails++;
        test_done();
    end
endmodule
